/* File: rtl/gpp_defs.svh */
// Register offsets, reset values and fixed figures of the port block
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH
`define GPP_OFF_DIR 12'h400
`define GPP_OFF_SENSE 12'h404
`define GPP_OFF_BOTH 12'h408
`define GPP_OFF_POL 12'h40C
`define GPP_OFF_MASK 12'h410
`define GPP_OFF_RAW 12'h414
`define GPP_OFF_MIS 12'h418
`define GPP_OFF_CLR 12'h41C
`define GPP_OFF_AFSEL 12'h420
`define GPP_OFF_DR2 12'h500
`define GPP_OFF_DR4 12'h504
`define GPP_OFF_DR8 12'h508
`define GPP_OFF_ODR 12'h50C
`define GPP_OFF_PUR 12'h510
`define GPP_OFF_PDR 12'h514
`define GPP_OFF_SLR 12'h518
`define GPP_OFF_DEN 12'h51C
`define GPP_OFF_LOCK 12'h520
`define GPP_OFF_COMMIT 12'h524
`define GPP_OFF_ID_FIRST 12'hFD0
`define GPP_RST_DR2 8'hFF
`define GPP_RST_AFSEL 8'h00
`define GPP_RST_PUR 8'h00
`define GPP_RST_DEN 8'h00
`define GPP_RST_COMMIT 8'hFF
`define GPP_UNLOCK_KEY 32'h5A5A_A5A5
`define GPP_TRIG_PIN 4
`endif

/* File: rtl/gpp_pkg.sv */
// Types shared by the port block
package gpp_pkg;
    typedef enum logic [1:0] {
        GPP_OKAY = 2'b00,
        GPP_SLVERR = 2'b10
    } gpp_resp_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] sense;
        logic [7:0] both;
        logic [7:0] pol;
        logic [7:0] mask;
        logic [7:0] raw;
        logic [7:0] afsel;
        logic [7:0] dr2;
        logic [7:0] dr4;
        logic [7:0] dr8;
        logic [7:0] odr;
        logic [7:0] pur;
        logic [7:0] pdr;
        logic [7:0] slr;
        logic [7:0] den;
        logic [7:0] commit;
        logic locked;
        logic [7:0] prev;
        logic aw_got;
        logic w_got;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        gpp_resp_t bresp;
        logic rvalid;
        gpp_resp_t rresp;
        logic [31:0] rdata;
    } gpp_state_t;
endpackage

/* File: rtl/gpp_port.sv */
// General-purpose port: register slave, pin muxing and interrupt detection
// Notes on behaviour
// - Address bits nine to two of a data access form a per-pin mask
// - Data register decoded over 256 word locations, one per mask value
// - Data write changes only bits whose address mask bit is one
// - Data read returns zero for every bit whose mask bit is zero
// - All pin interrupt conditions merge into one interrupt output
// - Edge events latch and stay pending until software clears them
// - Sense bit: zero selects edge, one selects level detection
// - Both-edges bit: zero single edge per polarity, one both edges
// - Polarity bit: zero low or falling, one high or rising
// - Mask bit zero blocks the pin from the interrupt output
// - Raw status shows the condition regardless of mask
// - Masked status is raw status ANDed with mask
// - Writing one to a clear bit drops that pending edge; zero ignored
// - Unmasked port B pin four interrupt also drives converter trigger
// - Changing sense, edge or polarity may raise spurious interrupts
// - Alternate-function bit hands the pin to its peripheral
// - Protected alternate-function bits need unlock plus commit to change
// - Reset leaves pins undriven except the debug-port pins
// - Per-pin drive, open-drain, pulls, slew and digital enable to pads
// - Fixed read-only identification registers
// - Port does nothing until its clock gate bit is set
// - Direction zero input, one driven output
// - Data read gives written value on outputs, pin value on inputs
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`include "gpp_defs.svh"
module gpp_port
    import gpp_pkg::*;
#(
    parameter bit IS_PORT_B = 1'b0,
    parameter logic [7:0] AFSEL_RST = `GPP_RST_AFSEL,
    parameter logic [7:0] PUR_RST = `GPP_RST_PUR,
    parameter logic [7:0] DEN_RST = `GPP_RST_DEN,
    parameter logic [7:0] COMMIT_RST = `GPP_RST_COMMIT,
    parameter logic [31:0] UNLOCK_KEY = `GPP_UNLOCK_KEY,
    // Arbitrary identity bytes, twelve words from the first id offset upward
    parameter logic [95:0] ID_VALUE = 96'h0C0B_0A09_0807_0605_0403_0201
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic periph_clk_en,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    output logic [7:0] alt_in,
    output logic [7:0] pad_drive_low,
    output logic [7:0] pad_drive_mid,
    output logic [7:0] pad_drive_high,
    output logic [7:0] pad_open_drain,
    output logic [7:0] pad_pull_up,
    output logic [7:0] pad_pull_down,
    output logic [7:0] pad_slew,
    output logic [7:0] pad_digital_en,
    output logic irq_out,
    output logic conv_trigger
);
    localparam gpp_state_t ST_RST = '{
        dr2: `GPP_RST_DR2, afsel: AFSEL_RST, pur: PUR_RST, den: DEN_RST,
        commit: COMMIT_RST, locked: 1'b1, bresp: GPP_OKAY, rresp: GPP_OKAY, default: '0};
    // Pins whose commit bit resets to zero are the protected ones
    localparam logic [7:0] PROT = ~COMMIT_RST;

    gpp_state_t s_ff;
    gpp_state_t nxt_s;
    logic [7:0] sync;
    logic [7:0] hit;
    logic [7:0] lvl;
    logic [7:0] clr;
    logic [7:0] wr_keep;
    logic wr_do;
    logic data_wr;
    logic [32:0] rd;

    gpp_sync #(.W(8)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pin_in),
        .q(sync)
    );

    for (genvar i = 0; i < 8; i++) begin : g_pin
        logic rise;
        logic fall;
        assign rise = sync[i] & ~s_ff.prev[i];
        assign fall = ~sync[i] & s_ff.prev[i];
        assign hit[i] = s_ff.both[i] ? (rise | fall) : (s_ff.pol[i] ? rise : fall);
        assign lvl[i] = s_ff.pol[i] ? sync[i] : ~sync[i];
    end

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a[11:10] == 2'b00) || (a >= `GPP_OFF_ID_FIRST) ||
            (a >= `GPP_OFF_DIR && a <= `GPP_OFF_AFSEL) ||
            (a >= `GPP_OFF_DR2 && a <= `GPP_OFF_COMMIT);
    endfunction

    // Read word with ok flag on top
    function automatic logic [32:0] rd_word(input logic [11:0] a);
        logic [7:0] v;
        logic [3:0] idx;
        v = 8'h00;
        idx = 4'(a[5:2] - 4'h4);
        if (a[11:10] == 2'b00) begin
            v = ((s_ff.dir & s_ff.data) | (~s_ff.dir & sync)) & a[9:2];
        end else if (a >= `GPP_OFF_ID_FIRST) begin
            v = ID_VALUE[idx*8 +: 8];
        end else begin
            case (a)
                `GPP_OFF_DIR: v = s_ff.dir;
                `GPP_OFF_SENSE: v = s_ff.sense;
                `GPP_OFF_BOTH: v = s_ff.both;
                `GPP_OFF_POL: v = s_ff.pol;
                `GPP_OFF_MASK: v = s_ff.mask;
                `GPP_OFF_RAW: v = s_ff.raw;
                `GPP_OFF_MIS: v = s_ff.raw & s_ff.mask;
                `GPP_OFF_AFSEL: v = s_ff.afsel;
                `GPP_OFF_DR2: v = s_ff.dr2;
                `GPP_OFF_DR4: v = s_ff.dr4;
                `GPP_OFF_DR8: v = s_ff.dr8;
                `GPP_OFF_ODR: v = s_ff.odr;
                `GPP_OFF_PUR: v = s_ff.pur;
                `GPP_OFF_PDR: v = s_ff.pdr;
                `GPP_OFF_SLR: v = s_ff.slr;
                `GPP_OFF_DEN: v = s_ff.den;
                `GPP_OFF_LOCK: v = {7'h00, s_ff.locked};
                `GPP_OFF_COMMIT: v = s_ff.commit;
                default: v = 8'h00;
            endcase
        end
        rd_word = {is_mapped(a) && periph_clk_en, 24'h00_0000, v};
    endfunction

    assign wr_do = s_ff.aw_got && s_ff.w_got;
    assign data_wr = wr_do && periph_clk_en && s_ff.wstrb[0] && (s_ff.awaddr[11:10] == 2'b00);
    // Bits of the alternate-function register that a write may change
    assign wr_keep = ~PROT | (s_ff.locked ? 8'h00 : s_ff.commit);
    // Process form, so a change of state also refreshes the read word
    always_comb begin
        rd = rd_word(s_axi_araddr);
    end

    always_comb begin
        nxt_s = s_ff;
        clr = 8'h00;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = s_axi_wdata;
            nxt_s.wstrb = s_axi_wstrb;
        end
        if (s_ff.bvalid && s_axi_bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (wr_do) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            // Gated port answers an error and keeps its state
            nxt_s.bresp = (is_mapped(s_ff.awaddr) && periph_clk_en) ? GPP_OKAY : GPP_SLVERR;
            if (data_wr) begin
                nxt_s.data = (s_ff.data & ~s_ff.awaddr[9:2]) |
                    (s_ff.wdata[7:0] & s_ff.awaddr[9:2]);
            end else if (periph_clk_en && s_ff.wstrb[0]) begin
                case (s_ff.awaddr)
                    `GPP_OFF_DIR: nxt_s.dir = s_ff.wdata[7:0];
                    `GPP_OFF_SENSE: nxt_s.sense = s_ff.wdata[7:0];
                    `GPP_OFF_BOTH: nxt_s.both = s_ff.wdata[7:0];
                    `GPP_OFF_POL: nxt_s.pol = s_ff.wdata[7:0];
                    `GPP_OFF_MASK: nxt_s.mask = s_ff.wdata[7:0];
                    `GPP_OFF_CLR: clr = s_ff.wdata[7:0];
                    `GPP_OFF_AFSEL: begin
                        nxt_s.afsel = (s_ff.afsel & ~wr_keep) | (s_ff.wdata[7:0] & wr_keep);
                    end
                    `GPP_OFF_DR2: nxt_s.dr2 = s_ff.wdata[7:0];
                    `GPP_OFF_DR4: nxt_s.dr4 = s_ff.wdata[7:0];
                    `GPP_OFF_DR8: nxt_s.dr8 = s_ff.wdata[7:0];
                    `GPP_OFF_ODR: nxt_s.odr = s_ff.wdata[7:0];
                    `GPP_OFF_PUR: nxt_s.pur = s_ff.wdata[7:0];
                    `GPP_OFF_PDR: nxt_s.pdr = s_ff.wdata[7:0];
                    `GPP_OFF_SLR: nxt_s.slr = s_ff.wdata[7:0];
                    `GPP_OFF_DEN: nxt_s.den = s_ff.wdata[7:0];
                    `GPP_OFF_LOCK: begin
                        // Only a full-word key unlocks; any other write with byte lane zero strobed relocks
                        nxt_s.locked = !((&s_ff.wstrb) && (s_ff.wdata == UNLOCK_KEY));
                    end
                    `GPP_OFF_COMMIT: begin
                        if (!s_ff.locked) begin
                            nxt_s.commit = ~PROT | (s_ff.wdata[7:0] & PROT);
                        end
                    end
                    default: nxt_s.commit = s_ff.commit;
                endcase
            end
        end
        if (s_ff.rvalid && s_axi_rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = rd[31:0];
            nxt_s.rresp = rd[32] ? GPP_OKAY : GPP_SLVERR;
        end
        if (periph_clk_en) begin
            nxt_s.prev = sync;
            // Edge pending: a new event wins over a clear in the same cycle
            nxt_s.raw = (s_ff.sense & lvl) |
                (~s_ff.sense & (hit | (s_ff.raw & ~clr)));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= ST_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready = !s_ff.aw_got && !s_ff.bvalid;
    assign s_axi_wready = !s_ff.w_got && !s_ff.bvalid;
    assign s_axi_bvalid = s_ff.bvalid;
    assign s_axi_bresp = s_ff.bresp;
    assign s_axi_arready = !s_ff.rvalid;
    assign s_axi_rvalid = s_ff.rvalid;
    assign s_axi_rdata = s_ff.rdata;
    assign s_axi_rresp = s_ff.rresp;

    // Open drain only ever pulls low
    assign pin_out = ((s_ff.afsel & alt_out) | (~s_ff.afsel & s_ff.data)) & ~s_ff.odr;
    assign pin_oe = s_ff.den & ((s_ff.afsel & alt_oe) | (~s_ff.afsel & s_ff.dir)) &
        ~(s_ff.odr & ((s_ff.afsel & alt_out) | (~s_ff.afsel & s_ff.data)));
    assign alt_in = sync;
    assign pad_drive_low = s_ff.dr2;
    assign pad_drive_mid = s_ff.dr4;
    assign pad_drive_high = s_ff.dr8;
    assign pad_open_drain = s_ff.odr;
    assign pad_pull_up = s_ff.pur;
    assign pad_pull_down = s_ff.pdr;
    assign pad_slew = s_ff.slr;
    assign pad_digital_en = s_ff.den;
    assign irq_out = |(s_ff.raw & s_ff.mask);
    assign conv_trigger = IS_PORT_B && s_ff.raw[`GPP_TRIG_PIN] && s_ff.mask[`GPP_TRIG_PIN];

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_data_mask_wr: assert property (
        data_wr |=> ((s_ff.data ^ $past(s_ff.data)) & ~$past(s_ff.awaddr[9:2])) == 8'h00)
        else $error("data bit outside mask changed");
    a_read_mask_zero: assert property (
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:10] == 2'b00)
        |=> (s_axi_rdata[7:0] & ~$past(s_axi_araddr[9:2])) == 8'h00 && s_axi_rdata[31:8] == 24'h0)
        else $error("masked-off data bit read as one");
    a_edge_hold: assert property (
        (!wr_do && periph_clk_en) |=> (s_ff.raw & $past(s_ff.raw & ~s_ff.sense))
        == $past(s_ff.raw & ~s_ff.sense))
        else $error("pending edge lost without a clear");
    a_clear_drop: assert property (
        (wr_do && periph_clk_en && s_ff.wstrb[0] && s_ff.awaddr == `GPP_OFF_CLR)
        |=> (s_ff.raw & ~s_ff.sense & $past(s_ff.wdata[7:0] & ~hit)) == 8'h00)
        else $error("clear did not drop pending edge");
    a_mask_block: assert property (
        (s_ff.mask == 8'h00) |-> !irq_out ##1 (s_ff.mask != 8'h00 || !irq_out))
        else $error("masked pin raised interrupt");
    a_trig_with_irq: assert property (
        conv_trigger |-> irq_out && s_ff.mask[`GPP_TRIG_PIN])
        else $error("trigger without port interrupt");
    a_lock_guard: assert property (
        s_ff.locked |=> ((s_ff.afsel ^ $past(s_ff.afsel)) & PROT) == 8'h00)
        else $error("protected bit changed while locked");
    a_gate_hold: assert property (
        !periph_clk_en |=> $stable(s_ff.data) && $stable(s_ff.raw) && $stable(s_ff.dir))
        else $error("gated port changed state");
    a_write_resp: assert property (
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_level_track: assert property (
        (!wr_do && periph_clk_en) |=> (s_ff.raw & s_ff.sense) == (s_ff.sense & $past(lvl)))
        else $error("level status does not follow pin");
    a_edge_set: assert property (
        (periph_clk_en && |(hit & ~s_ff.sense))
        |=> (s_ff.raw & $past(hit & ~s_ff.sense)) == $past(hit & ~s_ff.sense))
        else $error("detected edge not latched");
    a_gate_error: assert property (
        (wr_do && !periph_clk_en) |=> s_axi_bresp == GPP_SLVERR)
        else $error("gated write not refused");
    a_alt_drive: assert property (
        ((pin_out ^ alt_out) & s_ff.afsel & ~s_ff.odr) == 8'h00)
        else $error("peripheral pin not driven by peripheral");
    a_commit_hold: assert property (
        s_ff.locked |=> $stable(s_ff.commit))
        else $error("commit bits changed while locked");
    a_read_resp: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read response late");
    a_write_single: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");

    c_masked_write: cover property (data_wr && s_ff.awaddr[9:2] != 8'hFF);
    c_edge_irq: cover property (!s_ff.sense[0] && hit[0] ##1 irq_out);
    c_set_and_clear: cover property (wr_do && s_ff.awaddr == `GPP_OFF_CLR && |(hit & s_ff.wdata[7:0]));
    c_unlock_afsel: cover property (!s_ff.locked && wr_do && s_ff.awaddr == `GPP_OFF_AFSEL);
endmodule

/* File: rtl/gpp_sync.sv */
// Two-stage synchroniser for the pin inputs
module gpp_sync
    import gpp_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gpp_sync_st_t;

    gpp_sync_st_t s_ff;
    gpp_sync_st_t nxt_s;

    // First stage feeds only the second
    always_comb begin
        nxt_s.s1 = d;
        nxt_s.s2 = s_ff.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign q = s_ff.s2;
endmodule

/* File: tb/gpp_pin_model.sv */
// Behavioural model of the pads and the peripheral beside the port
module gpp_pin_model
    import gpp_pkg::*;
(
    input wire logic aclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pad_pull_up,
    input wire logic [7:0] pad_pull_down,
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in,
    output logic [7:0] alt_out,
    output logic [7:0] alt_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_ff = 8'h55;
    // Released pins wander, so a stale level never passes for a drive
    always_ff @(posedge aclk) begin
        float_ff <= ~float_ff;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_drive[i];
            else if (pad_pull_up[i]) pin_in[i] = 1'b1;
            else if (pad_pull_down[i]) pin_in[i] = 1'b0;
            else pin_in[i] = float_ff[i];
        end
    end
    // Peripheral owns the debug pin and drives it high
    assign alt_out = 8'h80;
    assign alt_oe = 8'h80;
endmodule

/* File: tb/gpp_port_data_irq_mode_tb.sv */
// Self-checking bench for the general-purpose port block
`include "gpp_defs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gpp_port_data_irq_mode_tb
    import gpp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, periph_clk_en;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, ext_drive, ext_en;
    logic [7:0] pad_drive_low, pad_drive_mid, pad_drive_high, pad_open_drain;
    logic [7:0] pad_pull_up, pad_pull_down, pad_slew, pad_digital_en;
    logic irq_out, conv_trigger;
    int fail_count = 0;
    int checks_done = 0;

    gpp_port #(.IS_PORT_B(1'b1), .AFSEL_RST(8'h80), .PUR_RST(8'h80), .DEN_RST(8'h80),
        .COMMIT_RST(8'h7F)) dut (.aclk, .aresetn, .periph_clk_en, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pin_in, .pin_out, .pin_oe, .alt_out, .alt_oe, .alt_in,
        .pad_drive_low, .pad_drive_mid, .pad_drive_high, .pad_open_drain, .pad_pull_up,
        .pad_pull_down, .pad_slew, .pad_digital_en, .irq_out, .conv_trigger);
    gpp_pin_model pins (.aclk, .pin_out, .pin_oe, .pad_pull_up, .pad_pull_down,
        .ext_drive, .ext_en, .pin_in, .alt_out, .alt_oe);

    always #2.5 aclk = ~aclk;

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) fail_count++;
        `CHK(s_axi_bresp, er)
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50) fail_count++;
        `CHK(s_axi_rdata, {24'h00_0000, e})
        `CHK(s_axi_rresp, er)
    endtask

    task automatic t_reset();
        `CHK(pad_drive_low, 8'hFF)
        `CHK({pad_pull_up, pad_digital_en, pad_pull_down}, 24'h80_8000)
        `CHK({pin_oe, pin_out}, 16'h8080)
        rd(`GPP_OFF_AFSEL, 8'h80, GPP_OKAY);
        rd(`GPP_OFF_COMMIT, 8'h7F, GPP_OKAY);
        rd(`GPP_OFF_LOCK, 8'h01, GPP_OKAY);
        $display("test reset done");
    endtask

    task automatic t_lock();
        wr(`GPP_OFF_AFSEL, 8'h00, GPP_OKAY);
        rd(`GPP_OFF_AFSEL, 8'h80, GPP_OKAY);
        wr(`GPP_OFF_COMMIT, 8'hFF, GPP_OKAY);
        rd(`GPP_OFF_COMMIT, 8'h7F, GPP_OKAY);
        wr(`GPP_OFF_LOCK, `GPP_UNLOCK_KEY, GPP_OKAY);
        rd(`GPP_OFF_LOCK, 8'h00, GPP_OKAY);
        wr(`GPP_OFF_COMMIT, 8'hFF, GPP_OKAY);
        wr(`GPP_OFF_AFSEL, 8'h00, GPP_OKAY);
        rd(`GPP_OFF_AFSEL, 8'h00, GPP_OKAY);
        `CHK(pin_oe, 8'h00)
        wr(`GPP_OFF_LOCK, 32'h0, GPP_OKAY);
        rd(`GPP_OFF_LOCK, 8'h01, GPP_OKAY);
        $display("test lock done");
    endtask

    task automatic t_data();
        ext_en <= 8'h00;
        wr(`GPP_OFF_DEN, 8'hFF, GPP_OKAY);
        wr(`GPP_OFF_DIR, 8'hFF, GPP_OKAY);
        wr(12'h3FC, 8'hFF, GPP_OKAY);
        wr(12'h098, 8'hEB, GPP_OKAY);
        wr(12'h000, 8'h00, GPP_OKAY);
        rd(12'h3FC, 8'hFB, GPP_OKAY);
        rd(12'h0C4, 8'h31, GPP_OKAY);
        `CHK({pin_out, pin_oe, pad_digital_en}, 24'hFB_FFFF)
        $display("test data done");
    endtask

    task automatic t_input();
        ext_drive <= 8'hA5;
        ext_en <= 8'hFF;
        wr(`GPP_OFF_DIR, 8'h00, GPP_OKAY);
        idle(4);
        rd(12'h3FC, 8'hA5, GPP_OKAY);
        rd(12'h0F0, 8'h24, GPP_OKAY);
        `CHK(alt_in, 8'hA5)
        $display("test input done");
    endtask

    task automatic t_irq();
        ext_drive <= 8'h00;
        wr(`GPP_OFF_SENSE, 8'h08, GPP_OKAY);
        wr(`GPP_OFF_BOTH, 8'h04, GPP_OKAY);
        wr(`GPP_OFF_POL, 8'h19, GPP_OKAY);
        wr(`GPP_OFF_MASK, 8'h1F, GPP_OKAY);
        idle(4);
        wr(`GPP_OFF_CLR, 8'hFF, GPP_OKAY);
        rd(`GPP_OFF_RAW, 8'h00, GPP_OKAY);
        ext_drive <= 8'h1D;
        idle(4);
        rd(`GPP_OFF_RAW, 8'h1D, GPP_OKAY);
        rd(`GPP_OFF_MIS, 8'h1D, GPP_OKAY);
        `CHK({irq_out, conv_trigger}, 2'h3)
        ext_drive <= 8'h00;
        idle(4);
        rd(`GPP_OFF_RAW, 8'h15, GPP_OKAY);
        wr(`GPP_OFF_MASK, 8'h02, GPP_OKAY);
        rd(`GPP_OFF_MIS, 8'h00, GPP_OKAY);
        `CHK({irq_out, conv_trigger}, 2'h0)
        rd(`GPP_OFF_RAW, 8'h15, GPP_OKAY);
        ext_drive <= 8'h02;
        idle(4);
        ext_drive <= 8'h00;
        idle(4);
        rd(`GPP_OFF_RAW, 8'h17, GPP_OKAY);
        `CHK(irq_out, 1'b1)
        wr(`GPP_OFF_CLR, 8'h01, GPP_OKAY);
        rd(`GPP_OFF_RAW, 8'h16, GPP_OKAY);
        wr(`GPP_OFF_CLR, 8'h16, GPP_OKAY);
        rd(`GPP_OFF_RAW, 8'h00, GPP_OKAY);
        `CHK(irq_out, 1'b0)
        $display("test irq done");
    endtask

    task automatic t_misc();
        @(posedge aclk);
        periph_clk_en <= 1'b0;
        wr(`GPP_OFF_DIR, 8'h55, GPP_SLVERR);
        rd(`GPP_OFF_DIR, 8'h00, GPP_SLVERR);
        periph_clk_en <= 1'b1;
        rd(`GPP_OFF_DIR, 8'h00, GPP_OKAY);
        wr(12'h600, 8'hFF, GPP_SLVERR);
        rd(12'h600, 8'h00, GPP_SLVERR);
        wr(`GPP_OFF_RAW, 8'hFF, GPP_OKAY);
        rd(`GPP_OFF_RAW, 8'h00, GPP_OKAY);
        wr(`GPP_OFF_ID_FIRST, 8'hFF, GPP_OKAY);
        rd(`GPP_OFF_ID_FIRST, 8'h01, GPP_OKAY);
        rd(12'hFFC, 8'h0C, GPP_OKAY);
        wr(`GPP_OFF_DR8, 8'h81, GPP_OKAY);
        wr(`GPP_OFF_DR4, 8'h3C, GPP_OKAY);
        wr(`GPP_OFF_ODR, 8'h0F, GPP_OKAY);
        wr(`GPP_OFF_PDR, 8'hC3, GPP_OKAY);
        wr(`GPP_OFF_SLR, 8'h5A, GPP_OKAY);
        `CHK({pad_drive_high, pad_drive_mid, pad_open_drain, pad_pull_down, pad_slew},
            40'h81_3C0F_C35A)
        $display("test misc done");
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles; this bound only cuts a hang
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        finish_test();
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        periph_clk_en = 1'b1;
        s_axi_wstrb = 4'hF;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        ext_drive = 8'h00;
        ext_en = 8'hFF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_lock();
        t_data();
        t_input();
        t_irq();
        t_misc();
        finish_test();
    end
endmodule
